//--- dv/dfr_host.sv
// host model presenting byte register requests as the serial port decoder would
// assumes callers enter its tasks in the time step of a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module dfr_host (
	input wire logic clock,
	output var dfr_pkg::dfr_req_t req
);
	import dfr_pkg::*;
	initial req = '0;
	// one request held through the edge that takes it
	task automatic op(input logic we, input logic re, input logic [7:0] a, input logic [7:0] d);
		req <= '{wrEn: we, rdEn: re, addr: a, wdata: d};
		@(posedge clock);
	endtask
	// released lines show the inverse of what they last carried, so repeated idles toggle them
	task automatic idle();
		req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
		@(posedge clock);
	endtask
endmodule
`default_nettype wire

//--- dv/tb_dfr_regs.sv
// self-checking bench for the receiver, fifo and datapath configuration registers
// assumes dfr_host drives the register port; the bench drives comparator and fifo inputs
`timescale 1ns/1ns
`default_nettype none
module tb_dfr_regs;
	import dfr_pkg::*;
	localparam logic [7:0] ADDRS [8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
	localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h0f, 8'h00, 8'he4, 8'h00};
	logic clock, rst_b, frameHiRaw, frameLoRaw, dclkHiRaw, dclkLoRaw, fifoAlignDone;
	logic [7:0] laneHiRaw, laneLoRaw, regRdData, d, m;
	logic [2:0] fifoWrPtr, fifoRdPtr;
	logic regRdValid, fifoAlignStart, qPathClkEn, qFromI, hbModulated;
	logic [3:0] dclkDelayTap;
	dfr_req_t regReq;
	dfr_cfg_t cfgOut;
	logic [7:0] expQ[$];
	logic [31:0] seed = 32'h000152d4;
	int errTotal = 0;
	int comparisons = 0;
	int n;

	dfr_host host_u (.clock(clock), .req(regReq));
	dfr_regs dut_u (.clock(clock), .rst_b(rst_b), .regReq(regReq), .regRdData(regRdData),
		.regRdValid(regRdValid), .frameHiRaw(frameHiRaw), .frameLoRaw(frameLoRaw),
		.dclkHiRaw(dclkHiRaw), .dclkLoRaw(dclkLoRaw), .laneHiRaw(laneHiRaw), .laneLoRaw(laneLoRaw),
		.fifoWrPtr(fifoWrPtr), .fifoRdPtr(fifoRdPtr), .fifoAlignDone(fifoAlignDone),
		.cfgOut(cfgOut), .dclkDelayTap(dclkDelayTap), .fifoAlignStart(fifoAlignStart),
		.qPathClkEn(qPathClkEn), .qFromI(qFromI), .hbModulated(hbModulated));

	always #50 clock = ~clock;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host_u.op(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		host_u.op(1'b1, 1'b0, a, dv);
	endtask

	task automatic settle(input int k);
		repeat (k) host_u.idle();
	endtask

	task automatic closeOut();
		$display("counts: %0d mismatches in %0d comparisons", errTotal, comparisons);
		if (errTotal == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// read results are compared against the oldest note in arrival order
	always @(posedge clock) begin
		if (regRdValid === 1'b1) begin
			if (expQ.size() == 0)
				chk(16'(regRdData), 16'h0100, "unexpected read");
			else
				chk(16'(regRdData), 16'(expQ.pop_front()), "read data");
		end
	end

	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		{frameHiRaw, frameLoRaw, dclkHiRaw, dclkLoRaw, fifoAlignDone} = 5'h00;
		laneHiRaw = 8'h00;
		laneLoRaw = 8'h00;
		fifoWrPtr = 3'h4;
		fifoRdPtr = 3'h0;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		// reset values, then writes to read-only and unmapped places
		for (int p = 0; p < 2; p++) begin
			if (p == 1) begin
				wr(8'h15, 8'hff);
				wr(8'h19, 8'hff);
				wr(8'h18, 8'hc4);
				wr(8'h1a, 8'hff);
			end
			foreach (ADDRS[i]) rd(ADDRS[i], RSTV[i]);
		end
		settle(2);
		chk(16'({dclkDelayTap, qPathClkEn, qFromI}), 16'h0006, "reset outputs");
		$display("test reset values done");
		// every low code of delay, datapath and half-band fields with random upper bits
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			d[2:0] = 3'(i);
			wr(8'h16, d);
			wr(8'h1b, d | 8'h20);
			wr(8'h1c, d);
			wr(8'h17, d);
			rd(8'h16, d & 8'h07);
			rd(8'h1b, (d | 8'h20) & 8'he7);
			rd(8'h1c, d & 8'h07);
			rd(8'h17, d & 8'h07);
			settle(1);
			chk(16'(dclkDelayTap), d[2] ? 16'h0000 : 16'(4'h1 << d[1:0]), "delay tap");
			chk(16'(cfgOut), 16'({d[2:0], d[2:0], d[7:6], 1'b1, d[2:0], d[2:0]}), "cfg");
			chk(16'({qFromI, qPathClkEn, hbModulated}), 16'({d[0], ~d[0], d[2]}), "q");
		end
		$display("test configuration fields done");
		// one comparator at a time, then all quiet again
		for (int k = 0; k < 7; k++) begin
			m = (k < 6) ? (8'h01 << k) : 8'h00;
			d = rnd();
			{frameHiRaw, frameLoRaw, dclkHiRaw, dclkLoRaw} <= m[5:2];
			laneHiRaw <= {7'h00, m[1]} << d[2:0];
			laneLoRaw <= {7'h00, m[0]} << d[5:3];
			settle(4);
			rd(8'h15, m);
		end
		$display("test level monitor done");
		// every pointer distance from random read positions
		for (int k = 0; k < 8; k++) begin
			d = rnd();
			fifoRdPtr <= d[2:0];
			fifoWrPtr <= d[2:0] + 3'(k);
			settle(2);
			rd(8'h18, {(k < 2 || k == 7), (k < 3 || k > 5), 6'h00});
			rd(8'h19, (8'h01 << k) - 8'h01);
		end
		fifoRdPtr <= 3'h0;
		fifoWrPtr <= 3'h4;
		settle(2);
		$display("test fifo monitor done");
		// soft alignment with the nominal phase offset
		wr(8'h17, 8'h04);
		wr(8'h18, 8'h02);
		n = 0;
		while (fifoAlignStart !== 1'b1 && n < 10) begin
			host_u.idle();
			n++;
		end
		if (n == 10) begin
			errTotal++;
			$display("mismatch at %0t: alignment start missing", $time);
			closeOut();
		end
		chk(16'(n), 16'h0002, "start latency");
		chk(16'(cfgOut.phaseOffset), 16'h0004, "offset");
		rd(8'h18, 8'h02);
		fifoAlignDone <= 1'b1;
		host_u.idle();
		fifoAlignDone <= 1'b0;
		rd(8'h18, 8'h04);
		settle(3);
		$display("test alignment done");
		for (n = 0; n < 10 && expQ.size() > 0; n++) host_u.idle();
		if (expQ.size() > 0) begin
			errTotal++;
			$display("mismatch at %0t: reads left unanswered", $time);
		end
		closeOut();
	end
endmodule
`default_nettype wire

//--- src/dfr_pkg.sv
// constants, carriers and state codes for the converter input receiver, fifo and datapath registers
// assumes one 10 MHz clock and a serial control port decoder that presents byte-wide register requests
//
// Functional notes
// R1: frame pair above upper threshold sets receiver status bit 5.
// R2: frame pair below lower threshold sets receiver status bit 4.
// R3: data clock above upper threshold sets bit 3, below lower sets bit 2.
// R4: any data lane above upper sets bit 1, below lower sets bit 0.
// R5: delay bypass bit 2 skips clock delay, else bits 1:0 pick it.
// R6: delay codes 00..11 give 165, 375, 615, 720 ps; reset 00.
// R7: fifo alignment places write pointer by three-bit phase offset, reset 4.
// R8: host should program the phase offset to four.
// R9: warning bit 7 within one entry, warning bit 6 within two.
// R10: writing one to fifo status bit 1 requests realignment; resets zero.
// R11: completed serial-port realignment sets acknowledge bit 2.
// R12: fifo fill level reads as eight-bit thermometer code.
// R13: datapath bits 7 and 6 bypass premodulator and inverse sinc; reset one.
// R14: host keeps datapath bit 5 at one; it resets to one.
// R15: datapath bit 2 bypasses phase compensation and dc offset; resets one.
// R16: sideband bit 1 picks high-side image at zero, low-side at one.
// R17: datapath bit 0 drops Q samples, gates Q clocks, sends I to both.
// R18: half-band mode 00 and 01 are unmodulated passbands.
// R19: half-band mode 10 and 11 modulate by the stage input rate.
// R20: half-band control bit 0 bypasses the first interpolation stage; resets zero.
// R21: level flags, warnings, acknowledge and level are read-only.
package dfr_pkg;

	localparam logic [7:0] ADDR_RX_LEVEL = 8'h15;
	localparam logic [7:0] ADDR_DLY_CTRL = 8'h16;
	localparam logic [7:0] ADDR_FIFO_OFS = 8'h17;
	localparam logic [7:0] ADDR_FIFO_STAT = 8'h18;
	localparam logic [7:0] ADDR_FIFO_LVL = 8'h19;
	localparam logic [7:0] ADDR_DP_CTRL = 8'h1b;
	localparam logic [7:0] ADDR_HB_CTRL = 8'h1c;

	localparam int RX_FRAME_HI = 5;
	localparam int RX_FRAME_LO = 4;
	localparam int RX_CLK_HI = 3;
	localparam int RX_CLK_LO = 2;
	localparam int RX_LANE_HI = 1;
	localparam int RX_LANE_LO = 0;

	localparam int DLY_BYPASS = 2;
	localparam int DLY_SEL_LSB = 0;
	localparam int FIFO_OFS_LSB = 0;
	localparam int FS_WARN1 = 7;
	localparam int FS_WARN2 = 6;
	localparam int FS_ACK = 2;
	localparam int FS_REQ = 1;
	localparam int DP_PREMOD = 7;
	localparam int DP_SINC = 6;
	localparam int DP_KEEP_ONE = 5;
	localparam int DP_PHASE_DC = 2;
	localparam int DP_SIDEBAND = 1;
	localparam int DP_I_TO_Q = 0;
	localparam int HB_MODE_LSB = 1;
	localparam int HB_BYPASS = 0;

	localparam logic [7:0] RST_DLY_CTRL = 8'h00;
	localparam logic [7:0] RST_FIFO_OFS = 8'h04;
	localparam logic [7:0] RST_DP_CTRL = 8'he4;
	localparam logic [7:0] RST_HB_CTRL = 8'h00;

	// clock delay taps in picoseconds, indexed by the delay select code
	localparam int DLY0_PS = 165;
	localparam int DLY1_PS = 375;
	localparam int DLY2_PS = 615;
	localparam int DLY3_PS = 720;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dfr_req_t;

	typedef struct packed {
		logic delayBypass;
		logic [1:0] delaySel;
		logic [2:0] phaseOffset;
		logic bypassPremod;
		logic bypassSinc;
		logic keepOne;
		logic bypassPhaseDc;
		logic lowSideband;
		logic iToQ;
		logic [1:0] hbMode;
		logic hbBypass;
	} dfr_cfg_t;

	typedef enum logic [1:0] {
		ALN_IDLE = 2'b01,
		ALN_BUSY = 2'b10
	} dfr_aln_t;

endpackage

//--- src/dfr_regs.sv
// receiver level status, clock delay, fifo and front datapath configuration registers
// assumes the serial port decoder presents one request per cycle and the fifo logic on this clock
`timescale 1ns/1ns
`default_nettype none
module dfr_regs #(
	parameter int LANES = 8,
	parameter int PTR_W = 3,
	parameter int LEVEL_W = 8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire dfr_pkg::dfr_req_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire logic frameHiRaw,
	input wire logic frameLoRaw,
	input wire logic dclkHiRaw,
	input wire logic dclkLoRaw,
	input wire logic [LANES-1:0] laneHiRaw,
	input wire logic [LANES-1:0] laneLoRaw,
	input wire logic [PTR_W-1:0] fifoWrPtr,
	input wire logic [PTR_W-1:0] fifoRdPtr,
	input wire logic fifoAlignDone,
	output dfr_pkg::dfr_cfg_t cfgOut,
	output logic [3:0] dclkDelayTap,
	output logic fifoAlignStart,
	output logic qPathClkEn,
	output logic qFromI,
	output logic hbModulated
);
	import dfr_pkg::*;

	localparam int SW = 4 + 2 * LANES;
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	localparam logic [PTR_W-1:0] PTR_TWO = PTR_W'(2);

	logic [SW-1:0] syncOut;
	logic frameHiSync;
	logic frameLoSync;
	logic dclkHiSync;
	logic dclkLoSync;
	logic laneHiAny;
	logic laneLoAny;
	logic [5:0] rxStatus_ff;
	logic warn1_ff;
	logic warn2_ff;
	logic [LEVEL_W-1:0] level_ff;
	logic [PTR_W-1:0] ptrDist;
	logic near1;
	logic near2;
	logic [LEVEL_W-1:0] nxt_level;
	logic alignReq_ff;
	logic alignAck_ff;
	dfr_aln_t alnState_ff;
	dfr_aln_t nxt_alnState;
	logic wrStat;
	logic reqWrite;
	logic [7:0] nxt_rdData;

	dfr_sync_bits #(
		.W(SW)
	) u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.din({laneLoRaw, laneHiRaw, dclkLoRaw, dclkHiRaw, frameLoRaw, frameHiRaw}),
		.dout(syncOut)
	);

	assign frameHiSync = syncOut[0];
	assign frameLoSync = syncOut[1];
	assign dclkHiSync = syncOut[2];
	assign dclkLoSync = syncOut[3];
	assign laneHiAny = |syncOut[4 +: LANES];
	assign laneLoAny = |syncOut[4 + LANES +: LANES];

	// input level monitor flags, hardware driven only
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxStatus_ff <= '0;
		end else begin
			rxStatus_ff[RX_FRAME_HI] <= frameHiSync; // R1
			rxStatus_ff[RX_FRAME_LO] <= frameLoSync; // R2
			rxStatus_ff[RX_CLK_HI] <= dclkHiSync; // R3
			rxStatus_ff[RX_CLK_LO] <= dclkLoSync; // R3
			rxStatus_ff[RX_LANE_HI] <= laneHiAny; // R4
			rxStatus_ff[RX_LANE_LO] <= laneLoAny; // R4
		end
	end

	// pointer distance, warnings and thermometer level
	assign ptrDist = fifoWrPtr - fifoRdPtr;
	assign near1 = (ptrDist <= PTR_ONE) || (ptrDist >= PTR_W'(-1)); // R9
	assign near2 = (ptrDist <= PTR_TWO) || (ptrDist >= PTR_W'(-2)); // R9

	always_comb begin
		nxt_level = '0;
		for (int i = 0; i < LEVEL_W; i++) begin
			nxt_level[i] = (32'(ptrDist) > i); // R12
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			warn1_ff <= 1'b0;
			warn2_ff <= 1'b0;
			level_ff <= '0;
		end else begin
			warn1_ff <= near1; // R9
			warn2_ff <= near2; // R9
			level_ff <= nxt_level; // R12
		end
	end

	// configuration registers; read-only locations take no write
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfgOut.delayBypass <= RST_DLY_CTRL[DLY_BYPASS];
			cfgOut.delaySel <= RST_DLY_CTRL[DLY_SEL_LSB +: 2];
			cfgOut.phaseOffset <= RST_FIFO_OFS[FIFO_OFS_LSB +: 3];
			cfgOut.bypassPremod <= RST_DP_CTRL[DP_PREMOD];
			cfgOut.bypassSinc <= RST_DP_CTRL[DP_SINC];
			cfgOut.keepOne <= RST_DP_CTRL[DP_KEEP_ONE];
			cfgOut.bypassPhaseDc <= RST_DP_CTRL[DP_PHASE_DC];
			cfgOut.lowSideband <= RST_DP_CTRL[DP_SIDEBAND];
			cfgOut.iToQ <= RST_DP_CTRL[DP_I_TO_Q];
			cfgOut.hbMode <= RST_HB_CTRL[HB_MODE_LSB +: 2];
			cfgOut.hbBypass <= RST_HB_CTRL[HB_BYPASS];
		end else if (regReq.wrEn) begin
			case (regReq.addr)
				ADDR_DLY_CTRL: begin
					cfgOut.delayBypass <= regReq.wdata[DLY_BYPASS]; // R5
					cfgOut.delaySel <= regReq.wdata[DLY_SEL_LSB +: 2]; // R6
				end
				ADDR_FIFO_OFS: begin
					cfgOut.phaseOffset <= regReq.wdata[FIFO_OFS_LSB +: 3]; // R7
				end
				ADDR_DP_CTRL: begin
					cfgOut.bypassPremod <= regReq.wdata[DP_PREMOD]; // R13
					cfgOut.bypassSinc <= regReq.wdata[DP_SINC]; // R13
					cfgOut.keepOne <= regReq.wdata[DP_KEEP_ONE]; // R14
					cfgOut.bypassPhaseDc <= regReq.wdata[DP_PHASE_DC]; // R15
					cfgOut.lowSideband <= regReq.wdata[DP_SIDEBAND]; // R16
					cfgOut.iToQ <= regReq.wdata[DP_I_TO_Q]; // R17
				end
				ADDR_HB_CTRL: begin
					cfgOut.hbMode <= regReq.wdata[HB_MODE_LSB +: 2]; // R18 R19
					cfgOut.hbBypass <= regReq.wdata[HB_BYPASS]; // R20
				end
				default: begin
				end
			endcase
		end
	end

	// derived datapath controls, one cycle behind the register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dclkDelayTap <= 4'h0;
			qPathClkEn <= 1'b1;
			qFromI <= 1'b0;
			hbModulated <= 1'b0;
		end else begin
			dclkDelayTap <= cfgOut.delayBypass ? 4'h0 : (4'h1 << cfgOut.delaySel); // R5 R6
			qPathClkEn <= !cfgOut.iToQ; // R17
			qFromI <= cfgOut.iToQ; // R17
			hbModulated <= cfgOut.hbMode[1]; // R19
		end
	end

	// soft alignment request, handshake with the fifo logic
	assign wrStat = regReq.wrEn && (regReq.addr == ADDR_FIFO_STAT);
	assign reqWrite = wrStat && regReq.wdata[FS_REQ];

	always_comb begin
		nxt_alnState = alnState_ff;
		case (alnState_ff)
			ALN_IDLE: begin
				if (alignReq_ff) begin
					nxt_alnState = ALN_BUSY;
				end
			end
			ALN_BUSY: begin
				if (fifoAlignDone) begin
					nxt_alnState = ALN_IDLE;
				end
			end
			default: begin
				nxt_alnState = ALN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			alnState_ff <= ALN_IDLE;
			fifoAlignStart <= 1'b0;
		end else begin
			alnState_ff <= nxt_alnState;
			fifoAlignStart <= (alnState_ff == ALN_IDLE) && alignReq_ff; // R7 R10
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			alignReq_ff <= 1'b0;
		end else if (reqWrite) begin
			alignReq_ff <= 1'b1; // R10
		end else if ((alnState_ff == ALN_BUSY) && fifoAlignDone) begin
			alignReq_ff <= 1'b0; // R10
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			alignAck_ff <= 1'b0;
		end else if ((alnState_ff == ALN_BUSY) && fifoAlignDone) begin
			alignAck_ff <= 1'b1; // R11
		end else if (reqWrite) begin
			alignAck_ff <= 1'b0;
		end
	end

	// read port; unmapped and reserved bits read as zero
	always_comb begin
		nxt_rdData = 8'h00;
		case (regReq.addr)
			ADDR_RX_LEVEL: begin
				nxt_rdData = {2'b00, rxStatus_ff}; // R21
			end
			ADDR_DLY_CTRL: begin
				nxt_rdData = {5'h00, cfgOut.delayBypass, cfgOut.delaySel};
			end
			ADDR_FIFO_OFS: begin
				nxt_rdData = {5'h00, cfgOut.phaseOffset};
			end
			ADDR_FIFO_STAT: begin
				nxt_rdData[FS_WARN1] = warn1_ff; // R21
				nxt_rdData[FS_WARN2] = warn2_ff;
				nxt_rdData[FS_ACK] = alignAck_ff;
				nxt_rdData[FS_REQ] = alignReq_ff;
			end
			ADDR_FIFO_LVL: begin
				nxt_rdData = 8'(level_ff); // R21
			end
			ADDR_DP_CTRL: begin
				nxt_rdData[DP_PREMOD] = cfgOut.bypassPremod;
				nxt_rdData[DP_SINC] = cfgOut.bypassSinc;
				nxt_rdData[DP_KEEP_ONE] = cfgOut.keepOne;
				nxt_rdData[DP_PHASE_DC] = cfgOut.bypassPhaseDc;
				nxt_rdData[DP_SIDEBAND] = cfgOut.lowSideband;
				nxt_rdData[DP_I_TO_Q] = cfgOut.iToQ;
			end
			ADDR_HB_CTRL: begin
				nxt_rdData = {5'h00, cfgOut.hbMode, cfgOut.hbBypass};
			end
			default: begin
				nxt_rdData = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regReq.rdEn;
			if (regReq.rdEn) begin
				regRdData <= nxt_rdData;
			end
		end
	end

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence alignWriteSeq;
		reqWrite && (alnState_ff == ALN_IDLE) && !alignReq_ff;
	endsequence

	sequence alignStartSeq;
		##1 alignReq_ff ##1 fifoAlignStart;
	endsequence

	chk_frame_high: assert property ($rose(frameHiRaw) ##1 frameHiRaw[*2] |=> rxStatus_ff[5]) // R1
		else $error("frame high flag missing");
	chk_frame_low: assert property (frameLoSync |=> rxStatus_ff[RX_FRAME_LO]) // R2
		else $error("frame low flag missing");
	chk_clock_levels: assert property (rxStatus_ff[RX_CLK_HI] == $past(dclkHiSync)
		&& rxStatus_ff[RX_CLK_LO] == $past(dclkLoSync)) // R3
		else $error("clock level flags wrong");
	chk_lane_levels: assert property ((laneHiAny && !laneLoAny) |=> (rxStatus_ff[1:0] == 2'b10)) // R4
		else $error("lane level flags wrong");
	chk_delay_bypass: assert property (cfgOut.delayBypass |=> dclkDelayTap == 4'h0) // R5
		else $error("delay tap active during bypass");
	chk_delay_select: assert property (!cfgOut.delayBypass && cfgOut.delaySel == 2'b10
		|=> dclkDelayTap == 4'h4) // R6
		else $error("delay tap does not follow select");
	chk_align_start: assert property (alignWriteSeq |-> alignStartSeq) // R7 R10
		else $error("alignment not started two cycles after request");
	chk_warn_one: assert property ((fifoWrPtr == fifoRdPtr) |=> warn1_ff && warn2_ff) // R9
		else $error("warnings clear with equal pointers");
	chk_warn_two: assert property ((ptrDist == PTR_TWO) |=> !warn1_ff && warn2_ff) // R9
		else $error("warning levels wrong at distance two");
	chk_align_ack: assert property ((alnState_ff == ALN_BUSY) && fifoAlignDone && !reqWrite
		|=> alignAck_ff && !alignReq_ff) // R11
		else $error("acknowledge not set after alignment");
	chk_level_therm: assert property ((ptrDist == PTR_TWO) |=> level_ff == LEVEL_W'(3)) // R12
		else $error("level thermometer wrong");
	chk_premod_write: assert property (regReq.wrEn && regReq.addr == ADDR_DP_CTRL
		|=> cfgOut.bypassPremod == $past(regReq.wdata[DP_PREMOD])) // R13
		else $error("premodulator bypass not written");
	chk_q_steer: assert property (cfgOut.iToQ |=> !qPathClkEn && qFromI) // R17
		else $error("Q path not gated");
	chk_hb_mode: assert property (cfgOut.hbMode[1] |=> hbModulated) // R19
		else $error("half-band modulation flag wrong");
	chk_status_ro: assert property (!reqWrite && (alnState_ff == ALN_IDLE)
		|=> $stable(alignAck_ff)) // R21
		else $error("read-only acknowledge changed by write");
	chk_hb_unmod: assert property (!cfgOut.hbMode[1] |=> !hbModulated) // R18
		else $error("half-band flagged modulated in unmodulated mode");
	chk_hb_bypass: assert property (regReq.wrEn && regReq.addr == ADDR_HB_CTRL
		|=> cfgOut.hbBypass == $past(regReq.wdata[HB_BYPASS])) // R20
		else $error("half-band bypass not written");
	chk_keep_write: assert property (regReq.wrEn && regReq.addr == ADDR_DP_CTRL
		|=> cfgOut.keepOne == $past(regReq.wdata[DP_KEEP_ONE])) // R14
		else $error("keep bit not written");
	chk_phase_dc: assert property (regReq.wrEn && regReq.addr == ADDR_DP_CTRL
		|=> cfgOut.bypassPhaseDc == $past(regReq.wdata[DP_PHASE_DC])) // R15
		else $error("phase and offset bypass not written");
	chk_sideband_wr: assert property (regReq.wrEn && regReq.addr == ADDR_DP_CTRL
		|=> cfgOut.lowSideband == $past(regReq.wdata[DP_SIDEBAND])) // R16
		else $error("sideband select not written");
	chk_offset_write: assert property (regReq.wrEn && regReq.addr == ADDR_FIFO_OFS
		|=> cfgOut.phaseOffset == $past(regReq.wdata[2:0])) // R7
		else $error("phase offset not written");
	chk_ack_clear: assert property (reqWrite && !((alnState_ff == ALN_BUSY) && fifoAlignDone)
		|=> !alignAck_ff && alignReq_ff) // R10 R11
		else $error("new request did not clear acknowledge");
	chk_read_valid: assert property (regReq.rdEn |=> regRdValid) // R21
		else $error("read valid missing");

endmodule
`default_nettype wire

//--- src/dfr_sync_bits.sv
// two-flop synchroniser for a bundle of independent level inputs
// assumes each bit is a slow level from a pin comparator, not a multi-bit word
`timescale 1ns/1ns
`default_nettype none
module dfr_sync_bits #(
	parameter int W = 4
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			dout <= '0;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule
`default_nettype wire
